// ---- common/ccs_map.svh ----
// Register map, field positions, reset values and counts of the configuration store control
// Notes on behaviour
// - Power-down bits: input loop bit 2, synth loop bit 1, distribution bit 0; reset 1.
// - Commit bit write copies every staged register to active on next serial clock edge.
// - Commit bit clears itself on the same serial clock edge that does the copy.
// - Twenty-three byte descriptors give byte count less one and start address of each moved range.
// - Descriptor list also holds a commit opcode and an end-of-data opcode.
// - Default descriptors move the route and power-down registers, then issue a commit at the end.
// - Read-only pending flag is 1 during a store transfer, 0 once it completes.
// - With status routing enabled, pending flag also drives status pin zero.
// - Read-only error flag is 1 when a reload transfer read a checksum that did not match its data; save transfers never set it.
// - With memory-select low, reload bit restores stored settings, then clears itself.
// - Write-enable bit 0 resets to 0 blocking store writes; 1 permits them.
// - Save bit starts copying staged bank to the store; returns to 0 when done.
`ifndef CCS_MAP_SVH
`define CCS_MAP_SVH

`define CCS_ADDR_ROUTE      12'h232
`define CCS_ROUTE_BIT       4
`define CCS_ADDR_PWR_DOWN   12'h233
`define CCS_PD_INPUT_BIT    2
`define CCS_PD_SYNTH_BIT    1
`define CCS_PD_DIST_BIT     0
`define CCS_PD_RESET        3'h7
`define CCS_ADDR_COMMIT     12'h234
`define CCS_COMMIT_BIT      0
`define CCS_DESC_BASE       12'hA00
`define CCS_DESC_LAST       12'hA16
`define CCS_DESC_COUNT      23
`define CCS_ADDR_PENDING    12'hB00
`define CCS_PEND_BIT        0
`define CCS_ADDR_ERROR      12'hB01
`define CCS_ERR_BIT         0
`define CCS_ADDR_CTL1       12'hB02
`define CCS_WE_BIT          0
`define CCS_RELOAD_BIT      1
`define CCS_ADDR_CTL2       12'hB03
`define CCS_SAVE_BIT        0
`define CCS_OP_COMMIT       8'h80
`define CCS_OP_END          8'hFF
`define CCS_DESC_DEF0       8'h01
`define CCS_DESC_DEF1       8'h02
`define CCS_DESC_DEF2       8'h32
`define CCS_DESC_DEF3       8'h80
`define CCS_DESC_DEF4       8'hFF
`define CCS_DESC_FILL       8'h00
`define CCS_NVM_AW          6
`define CCS_WR_WAIT         4

`endif

// ---- common/ccs_pkg.sv ----
// Types shared by the configuration store control
package ccs_pkg;
  typedef logic [11:0] ccs_addr_t;
  typedef logic [7:0]  ccs_byte_t;
  typedef enum logic [2:0] {
    eng_idle,
    eng_op,
    eng_hi,
    eng_lo,
    eng_xfer,
    eng_wait,
    eng_sum,
    eng_sumw
  } ccs_eng_state_t;
endpackage

// ---- rtl/ccs_store_mem.sv ----
// Nonvolatile store model on the reference clock with a toggle handshake port
`include "ccs_map.svh"
module ccs_store_mem #(
  parameter int AW   = `CCS_NVM_AW,
  parameter int WAIT = `CCS_WR_WAIT
) (
  input  wire logic              clk_in,
  input  wire logic              rst_b_in,
  input  wire logic              req_tgl_in,
  input  wire logic              req_wr_in,
  input  wire logic [AW-1:0]     req_addr_in,
  input  wire ccs_pkg::ccs_byte_t req_data_in,
  output logic                   ack_tgl_out,
  output ccs_pkg::ccs_byte_t     rdata_out
);
  import ccs_pkg::*;
  localparam int CW = $clog2(WAIT + 1);

  logic            req_s1_ff;
  logic            req_s2_ff;
  logic            req_prev_ff;
  logic            busy_ff;
  logic [CW-1:0]   cnt_ff;
  logic            ack_ff;
  ccs_byte_t       rdata_ff;
  ccs_byte_t       mem_ff [2**AW];

  wire req_evt = (req_s2_ff ^ req_prev_ff) && !busy_ff;
  wire done    = busy_ff && (cnt_ff == '0);

  assign ack_tgl_out = ack_ff;
  assign rdata_out   = rdata_ff;

  always_ff @(posedge clk_in) begin
    req_s1_ff   <= rst_b_in ? req_tgl_in : 1'b0;
    req_s2_ff   <= rst_b_in ? req_s1_ff : 1'b0;
    req_prev_ff <= rst_b_in ? req_s2_ff : 1'b0;
  end

  // Hold each request for the programming time, then answer with readback
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      busy_ff  <= 1'b0;
      cnt_ff   <= '0;
      ack_ff   <= 1'b0;
      rdata_ff <= 8'h00;
      for (int i = 0; i < 2**AW; i++) begin
        mem_ff[i] <= 8'h00;
      end
    end else if (req_evt) begin
      busy_ff <= 1'b1;
      cnt_ff  <= CW'(WAIT - 1);
      if (req_wr_in) begin
        mem_ff[req_addr_in] <= req_data_in;
      end
    end else if (done) begin
      busy_ff  <= 1'b0;
      rdata_ff <= mem_ff[req_addr_in];
      ack_ff   <= ~ack_ff;
    end else if (busy_ff) begin
      cnt_ff <= cnt_ff - 1'b1;
    end
  end
endmodule

// ---- rtl/ccs_top.sv ----
// Configuration store control: staged/active registers, commit and store transfer engine
`include "ccs_map.svh"
module ccs_top #(
  parameter int NVM_AW   = `CCS_NVM_AW,
  parameter int NUM_DESC = `CCS_DESC_COUNT,
  parameter int WR_WAIT  = `CCS_WR_WAIT
) (
  input  wire logic               ref_clk_in,
  input  wire logic               rst_b_in,
  input  wire logic               sclk_in,
  input  wire logic               mem_sel_in,
  input  wire logic               reg_wr_in,
  input  wire ccs_pkg::ccs_addr_t reg_addr_in,
  input  wire ccs_pkg::ccs_byte_t reg_wdata_in,
  output ccs_pkg::ccs_byte_t      reg_rdata_out,
  output logic                    input_loop_power_down_out,
  output logic                    synth_loop_power_down_out,
  output logic                    dist_power_down_out,
  output logic                    status_pin_zero_out
);
  import ccs_pkg::*;
  localparam int IW = $clog2(NUM_DESC + 1);

  // Link domain state
  logic            lrst_s1_ff;
  logic            lrst_s2_ff;
  logic            msel_s1_ff;
  logic            msel_s2_ff;
  logic            ack_s1_ff;
  logic            ack_s2_ff;
  logic            ack_prev_ff;
  logic [2:0]      stg_pd_ff;
  logic [2:0]      act_pd_ff;
  logic            stg_route_ff;
  logic            act_route_ff;
  logic            commit_ff;
  ccs_byte_t       desc_ff [NUM_DESC];
  logic            nvm_we_ff;
  logic            reload_ff;
  logic            save_ff;
  logic            busy_ff;
  logic            err_ff;
  logic            dir_save_ff;
  ccs_byte_t       rdata_ff;
  ccs_eng_state_t  st_ff;
  logic [IW-1:0]   idx_ff;
  logic [6:0]      cnt_ff;
  ccs_addr_t       xaddr_ff;
  logic [NVM_AW-1:0] ptr_ff;
  ccs_byte_t       sum_ff;
  logic            req_tgl_ff;
  logic            req_wr_ff;
  logic [NVM_AW-1:0] req_addr_ff;
  ccs_byte_t       req_data_ff;

  // Reference domain state
  logic            busy_s1_ff;
  logic            busy_s2_ff;
  logic            route_s1_ff;
  logic            route_s2_ff;
  logic            status_ff;

  ccs_eng_state_t  nxt_st;
  logic [IW-1:0]   nxt_idx;
  logic [6:0]      nxt_cnt;
  ccs_addr_t       nxt_xaddr;
  logic [NVM_AW-1:0] nxt_ptr;
  ccs_byte_t       nxt_sum;
  logic            nxt_req_tgl;
  logic            nxt_req_wr;
  logic [NVM_AW-1:0] nxt_req_addr;
  ccs_byte_t       nxt_req_data;

  logic            nvm_ack_tgl;
  ccs_byte_t       nvm_rdata;

  function automatic ccs_byte_t desc_default(input int i);
    case (i)
      0:       desc_default = `CCS_DESC_DEF0;
      1:       desc_default = `CCS_DESC_DEF1;
      2:       desc_default = `CCS_DESC_DEF2;
      3:       desc_default = `CCS_DESC_DEF3;
      4:       desc_default = `CCS_DESC_DEF4;
      default: desc_default = `CCS_DESC_FILL;
    endcase
  endfunction

  // Register readback; unmapped addresses and reserved bits read zero
  function automatic ccs_byte_t rd_byte(input ccs_addr_t a);
    ccs_byte_t r;
    ccs_addr_t off;
    r   = 8'h00;
    off = a - `CCS_DESC_BASE;
    if (a == `CCS_ADDR_ROUTE) begin
      r[`CCS_ROUTE_BIT] = stg_route_ff;
    end
    if (a == `CCS_ADDR_PWR_DOWN) begin
      r[2:0] = stg_pd_ff;
    end
    if (a == `CCS_ADDR_COMMIT) begin
      r[`CCS_COMMIT_BIT] = commit_ff;
    end
    if (a >= `CCS_DESC_BASE && a <= `CCS_DESC_LAST && off < NUM_DESC) begin
      r = desc_ff[off[IW-1:0]];
    end
    if (a == `CCS_ADDR_PENDING) begin
      r[`CCS_PEND_BIT] = busy_ff;
    end
    if (a == `CCS_ADDR_ERROR) begin
      r[`CCS_ERR_BIT] = err_ff;
    end
    if (a == `CCS_ADDR_CTL1) begin
      r[`CCS_WE_BIT]     = nvm_we_ff;
      r[`CCS_RELOAD_BIT] = reload_ff;
    end
    if (a == `CCS_ADDR_CTL2) begin
      r[`CCS_SAVE_BIT] = save_ff;
    end
    return r;
  endfunction

  // Link-domain reset and pin synchronisers
  wire link_rst_b = lrst_s2_ff;

  always_ff @(posedge sclk_in) begin
    lrst_s1_ff <= rst_b_in;
    lrst_s2_ff <= lrst_s1_ff;
    msel_s1_ff <= mem_sel_in;
    msel_s2_ff <= msel_s1_ff;
    ack_s1_ff  <= nvm_ack_tgl;
    ack_s2_ff  <= ack_s1_ff;
  end

  // Shared write port: an engine restore write takes priority over the host
  wire            ack_evt   = ack_s2_ff ^ ack_prev_ff;
  wire            eng_wr    = (st_ff == eng_wait) && ack_evt && !dir_save_ff;
  wire            host_wr   = reg_wr_in && !eng_wr;
  wire            wr_en     = eng_wr || host_wr;
  wire ccs_addr_t wr_addr   = eng_wr ? xaddr_ff : reg_addr_in;
  wire ccs_byte_t wr_data   = eng_wr ? nvm_rdata : reg_wdata_in;
  wire ccs_addr_t wr_off    = wr_addr - `CCS_DESC_BASE;
  wire            wr_route  = wr_en && (wr_addr == `CCS_ADDR_ROUTE);
  wire            wr_pd     = wr_en && (wr_addr == `CCS_ADDR_PWR_DOWN);
  wire            wr_commit = wr_en && (wr_addr == `CCS_ADDR_COMMIT);
  wire            wr_desc   = wr_en && (wr_addr >= `CCS_DESC_BASE) && (wr_addr <= `CCS_DESC_LAST);
  wire            wr_ctl1   = wr_en && (wr_addr == `CCS_ADDR_CTL1);
  wire            wr_ctl2   = wr_en && (wr_addr == `CCS_ADDR_CTL2);
  wire [IW-1:0]   wr_didx   = wr_off[IW-1:0];

  // Transfer starts and opcode decode
  wire reload_go = wr_ctl1 && wr_data[`CCS_RELOAD_BIT] && !msel_s2_ff && !busy_ff;
  wire save_go   = wr_ctl2 && wr_data[`CCS_SAVE_BIT] && nvm_we_ff && !busy_ff;
  wire start     = reload_go || save_go;
  wire ccs_byte_t desc_cur = (idx_ff < NUM_DESC) ? desc_ff[idx_ff] : `CCS_OP_END;
  wire op_commit = (st_ff == eng_op) && (desc_cur == `CCS_OP_COMMIT);
  wire commit_set = (wr_commit && wr_data[`CCS_COMMIT_BIT]) || op_commit;
  wire fin       = (st_ff == eng_sumw) && ack_evt;
  wire sum_bad   = fin && !dir_save_ff && (nvm_rdata != sum_ff);
  wire ccs_byte_t xfer_byte = dir_save_ff ? req_data_ff : nvm_rdata;

  // Staged bank, active bank and commit
  always_ff @(posedge sclk_in) begin
    if (!link_rst_b) begin
      stg_pd_ff    <= `CCS_PD_RESET;
      act_pd_ff    <= `CCS_PD_RESET;
      stg_route_ff <= 1'b0;
      act_route_ff <= 1'b0;
      commit_ff    <= 1'b0;
    end else begin
      if (wr_route) begin
        stg_route_ff <= wr_data[`CCS_ROUTE_BIT];
      end
      if (wr_pd) begin
        stg_pd_ff <= wr_data[2:0];
      end
      if (commit_ff) begin
        act_pd_ff    <= stg_pd_ff;
        act_route_ff <= stg_route_ff;
      end
      commit_ff <= commit_set;
    end
  end

  // Descriptor table
  always_ff @(posedge sclk_in) begin
    if (!link_rst_b) begin
      for (int i = 0; i < NUM_DESC; i++) begin
        desc_ff[i] <= desc_default(i);
      end
    end else if (wr_desc && (wr_off < NUM_DESC)) begin
      desc_ff[wr_didx] <= wr_data;
    end
  end

  // Store control and status bits
  always_ff @(posedge sclk_in) begin
    if (!link_rst_b) begin
      nvm_we_ff   <= 1'b0;
      reload_ff   <= 1'b0;
      save_ff     <= 1'b0;
      busy_ff     <= 1'b0;
      err_ff      <= 1'b0;
      dir_save_ff <= 1'b0;
    end else begin
      if (wr_ctl1) begin
        nvm_we_ff <= wr_data[`CCS_WE_BIT];
      end
      reload_ff   <= reload_go || (reload_ff && !fin);
      save_ff     <= save_go || (save_ff && !fin);
      busy_ff     <= start || (busy_ff && !fin);
      err_ff      <= sum_bad || (err_ff && !start);
      dir_save_ff <= start ? save_go : dir_save_ff;
    end
  end

  // Transfer engine walks the descriptor list
  always_comb begin
    nxt_st       = st_ff;
    nxt_idx      = idx_ff;
    nxt_cnt      = cnt_ff;
    nxt_xaddr    = xaddr_ff;
    nxt_ptr      = ptr_ff;
    nxt_sum      = sum_ff;
    nxt_req_tgl  = req_tgl_ff;
    nxt_req_wr   = req_wr_ff;
    nxt_req_addr = req_addr_ff;
    nxt_req_data = req_data_ff;
    case (st_ff)
      eng_idle: begin
        if (start) begin
          nxt_st  = eng_op;
          nxt_idx = '0;
          nxt_ptr = '0;
          nxt_sum = 8'h00;
        end
      end
      eng_op: begin
        if (desc_cur == `CCS_OP_END) begin
          nxt_st = eng_sum;
        end else begin
          nxt_idx = idx_ff + 1'b1;
          if (desc_cur != `CCS_OP_COMMIT) begin
            nxt_cnt = desc_cur[6:0];
            nxt_st  = eng_hi;
          end
        end
      end
      eng_hi: begin
        nxt_xaddr = {desc_cur[3:0], 8'h00};
        nxt_idx   = idx_ff + 1'b1;
        nxt_st    = eng_lo;
      end
      eng_lo: begin
        nxt_xaddr = {xaddr_ff[11:8], desc_cur};
        nxt_idx   = idx_ff + 1'b1;
        nxt_st    = eng_xfer;
      end
      eng_xfer: begin
        nxt_req_wr   = dir_save_ff;
        nxt_req_addr = ptr_ff;
        nxt_req_data = rd_byte(xaddr_ff);
        nxt_req_tgl  = ~req_tgl_ff;
        nxt_st       = eng_wait;
      end
      eng_wait: begin
        if (ack_evt) begin
          nxt_sum   = sum_ff + xfer_byte;
          nxt_ptr   = ptr_ff + 1'b1;
          nxt_xaddr = xaddr_ff + 1'b1;
          if (cnt_ff == 7'h00) begin
            nxt_st = eng_op;
          end else begin
            nxt_cnt = cnt_ff - 7'h01;
            nxt_st  = eng_xfer;
          end
        end
      end
      eng_sum: begin
        nxt_req_wr   = dir_save_ff;
        nxt_req_addr = ptr_ff;
        nxt_req_data = sum_ff;
        nxt_req_tgl  = ~req_tgl_ff;
        nxt_st       = eng_sumw;
      end
      eng_sumw: begin
        if (ack_evt) begin
          nxt_st = eng_idle;
        end
      end
      default: begin
        nxt_st = eng_idle;
      end
    endcase
  end

  always_ff @(posedge sclk_in) begin
    if (!link_rst_b) begin
      st_ff       <= eng_idle;
      idx_ff      <= '0;
      cnt_ff      <= 7'h00;
      xaddr_ff    <= 12'h000;
      ptr_ff      <= '0;
      sum_ff      <= 8'h00;
      req_tgl_ff  <= 1'b0;
      req_wr_ff   <= 1'b0;
      req_addr_ff <= '0;
      req_data_ff <= 8'h00;
      ack_prev_ff <= 1'b0;
      rdata_ff    <= 8'h00;
    end else begin
      st_ff       <= nxt_st;
      idx_ff      <= nxt_idx;
      cnt_ff      <= nxt_cnt;
      xaddr_ff    <= nxt_xaddr;
      ptr_ff      <= nxt_ptr;
      sum_ff      <= nxt_sum;
      req_tgl_ff  <= nxt_req_tgl;
      req_wr_ff   <= nxt_req_wr;
      req_addr_ff <= nxt_req_addr;
      req_data_ff <= nxt_req_data;
      ack_prev_ff <= ack_s2_ff;
      rdata_ff    <= rd_byte(reg_addr_in);
    end
  end

  // Store on the reference clock; request words stay stable until acknowledged
  ccs_store_mem #(
    .AW   (NVM_AW),
    .WAIT (WR_WAIT)
  ) u_store (
    .clk_in      (ref_clk_in),
    .rst_b_in    (rst_b_in),
    .req_tgl_in  (req_tgl_ff),
    .req_wr_in   (req_wr_ff),
    .req_addr_in (req_addr_ff),
    .req_data_in (req_data_ff),
    .ack_tgl_out (nvm_ack_tgl),
    .rdata_out   (nvm_rdata)
  );

  // Status pin zero on the reference clock
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      busy_s1_ff  <= 1'b0;
      busy_s2_ff  <= 1'b0;
      route_s1_ff <= 1'b0;
      route_s2_ff <= 1'b0;
      status_ff   <= 1'b0;
    end else begin
      busy_s1_ff  <= busy_ff;
      busy_s2_ff  <= busy_s1_ff;
      route_s1_ff <= act_route_ff;
      route_s2_ff <= route_s1_ff;
      status_ff   <= busy_s2_ff && route_s2_ff;
    end
  end

  assign reg_rdata_out             = rdata_ff;
  assign input_loop_power_down_out = act_pd_ff[`CCS_PD_INPUT_BIT];
  assign synth_loop_power_down_out = act_pd_ff[`CCS_PD_SYNTH_BIT];
  assign dist_power_down_out       = act_pd_ff[`CCS_PD_DIST_BIT];
  assign status_pin_zero_out       = status_ff;
endmodule

// ---- tb/ccs_top_chk.sv ----
// Concurrent checks on the configuration store control ports
`include "ccs_map.svh"
module ccs_top_chk #(
  parameter int NVM_AW   = `CCS_NVM_AW,
  parameter int NUM_DESC = `CCS_DESC_COUNT,
  parameter int WR_WAIT  = `CCS_WR_WAIT
) (
  input wire logic               rst_b_in,
  input wire logic               sclk_in,
  input wire logic               reg_wr_in,
  input wire ccs_pkg::ccs_addr_t reg_addr_in,
  input wire ccs_pkg::ccs_byte_t reg_wdata_in,
  input wire ccs_pkg::ccs_byte_t reg_rdata_out,
  input wire logic               input_loop_power_down_out,
  input wire logic               synth_loop_power_down_out,
  input wire logic               dist_power_down_out
);
  import ccs_pkg::*;
  localparam ccs_addr_t DESC_END = ccs_addr_t'(`CCS_DESC_BASE + NUM_DESC);
  logic       we_ff;
  logic       nxt_we;
  wire        we_wr     = reg_wr_in && (reg_addr_in == `CCS_ADDR_CTL1);
  wire        save_wr   = reg_wr_in && (reg_addr_in == `CCS_ADDR_CTL2) && reg_wdata_in[0];
  wire        commit_wr = reg_wr_in && (reg_addr_in == `CCS_ADDR_COMMIT) && reg_wdata_in[0];
  wire        pend_rd   = reg_addr_in == `CCS_ADDR_PENDING;
  wire  [2:0] pd_out    = {input_loop_power_down_out, synth_loop_power_down_out,
                           dist_power_down_out};
  // Host view of the write-enable bit
  assign nxt_we = we_wr ? reg_wdata_in[0] : we_ff;
  always_ff @(posedge sclk_in) begin
    if (!rst_b_in) we_ff <= 1'b0;
    else we_ff <= nxt_we;
  end
  default clocking cb @(posedge sclk_in); endclocking
  default disable iff (!rst_b_in);
  property p_commit_pd;
    (reg_wr_in && reg_addr_in == `CCS_ADDR_PWR_DOWN) ##1 commit_wr |=> ##2
      pd_out == $past(reg_wdata_in[2:0], 4);
  endproperty
  a_commit_pd: assert property (p_commit_pd)
    else $error("power-down outputs differ from committed value");
  property p_commit_clear;
    commit_wr ##1 (reg_addr_in == `CCS_ADDR_COMMIT)[*3] |=> reg_rdata_out[0] == 1'b0;
  endproperty
  a_commit_clear: assert property (p_commit_clear)
    else $error("commit bit did not clear");
  property p_pd_rsvd;
    (reg_addr_in == `CCS_ADDR_PWR_DOWN)[*2] |=> reg_rdata_out[7:3] == 5'h00;
  endproperty
  a_pd_rsvd: assert property (p_pd_rsvd)
    else $error("power-down reserved bits not zero");
  property p_desc_end;
    (reg_addr_in == DESC_END)[*2] |=> reg_rdata_out == 8'h00;
  endproperty
  a_desc_end: assert property (p_desc_end)
    else $error("address past descriptor table reads nonzero");
  property p_pend_rsvd;
    pend_rd[*2] |=> reg_rdata_out[7:1] == 7'h00;
  endproperty
  a_pend_rsvd: assert property (p_pend_rsvd)
    else $error("pending register reserved bits not zero");
  property p_err_rsvd;
    (reg_addr_in == `CCS_ADDR_ERROR)[*2] |=> reg_rdata_out[7:1] == 7'h00;
  endproperty
  a_err_rsvd: assert property (p_err_rsvd)
    else $error("error register reserved bits not zero");
  property p_save_refused;
    (save_wr && !we_ff) ##1 pend_rd[*3] |=> reg_rdata_out[0] == 1'b0;
  endproperty
  a_save_refused: assert property (p_save_refused)
    else $error("save without write enable set pending");
  property p_save_start;
    (save_wr && we_ff) ##1 pend_rd[*3] |=> reg_rdata_out[0] == 1'b1;
  endproperty
  a_save_start: assert property (p_save_start)
    else $error("save did not set pending");
  property p_pend_falls;
    (pend_rd[*2] ##0 reg_rdata_out[0]) |-> ##[1:1000] (pend_rd && !reg_rdata_out[0]);
  endproperty
  a_pend_falls: assert property (p_pend_falls)
    else $error("pending flag never cleared");
endmodule
bind ccs_top ccs_top_chk #(.NVM_AW(NVM_AW), .NUM_DESC(NUM_DESC), .WR_WAIT(WR_WAIT)) i_chk (
  .rst_b_in                  (rst_b_in),
  .sclk_in                   (sclk_in),
  .reg_wr_in                 (reg_wr_in),
  .reg_addr_in               (reg_addr_in),
  .reg_wdata_in              (reg_wdata_in),
  .reg_rdata_out             (reg_rdata_out),
  .input_loop_power_down_out (input_loop_power_down_out),
  .synth_loop_power_down_out (synth_loop_power_down_out),
  .dist_power_down_out       (dist_power_down_out)
);

// ---- tb/ccs_host_model.sv ----
// Host controller model: serial clock and register write and read cycles
module ccs_host_model (
  output logic                    sclk_out,
  output logic                    reg_wr_out,
  output ccs_pkg::ccs_addr_t      reg_addr_out,
  output ccs_pkg::ccs_byte_t      reg_wdata_out,
  input  wire ccs_pkg::ccs_byte_t reg_rdata_in
);
  timeunit 1ns;
  timeprecision 100ps;
  import ccs_pkg::*;
  initial begin
    sclk_out      = 1'b0;
    reg_wr_out    = 1'b0;
    reg_addr_out  = 12'h000;
    reg_wdata_out = 8'h00;
    #1.7;
    forever #3 sclk_out = ~sclk_out;
  end
  // Write: strobe stays up until the next cycle begins, so writes can run back to back
  task automatic wr(input ccs_addr_t a, input ccs_byte_t d);
    @(posedge sclk_out);
    reg_wr_out    <= 1'b1;
    reg_addr_out  <= a;
    reg_wdata_out <= d;
  endtask
  // Read: address held two edges; released data lines show the inverse
  task automatic rd(input ccs_addr_t a, output ccs_byte_t d);
    @(posedge sclk_out);
    reg_wr_out    <= 1'b0;
    reg_wdata_out <= ~reg_wdata_out;
    reg_addr_out  <= a;
    repeat (2) @(posedge sclk_out);
    #1;
    d = reg_rdata_in;
  endtask
endmodule

// ---- tb/ccs_tb_top.sv ----
// Self-checking bench of the configuration store control
module ccs_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import ccs_pkg::*;
  typedef struct {
    logic      wr;
    ccs_addr_t addr;
    ccs_byte_t data;
    ccs_byte_t exp;
  } ccs_row_t;
  logic      ref_clk_in;
  logic      rst_b_in;
  logic      mem_sel_in;
  wire       sclk;
  wire       host_wr;
  ccs_addr_t host_addr;
  ccs_byte_t host_wdata;
  ccs_byte_t rdata;
  logic      pd_in;
  logic      pd_syn;
  logic      pd_dist;
  logic      stat;
  int        failures;
  int        check_count;
  int        cycles;
  ccs_row_t  rows [15] = '{
    '{1'b0, 12'h233, 8'h00, 8'h07}, '{1'b0, 12'h234, 8'h00, 8'h00},
    '{1'b0, 12'hA00, 8'h00, 8'h01}, '{1'b0, 12'hA03, 8'h00, 8'h80},
    '{1'b0, 12'hA04, 8'h00, 8'hFF}, '{1'b0, 12'hA16, 8'h00, 8'h00},
    '{1'b1, 12'hA16, 8'h5A, 8'h5A}, '{1'b1, 12'hA16, 8'h00, 8'h00},
    '{1'b0, 12'hA17, 8'h00, 8'h00}, '{1'b1, 12'h233, 8'hFA, 8'h02},
    '{1'b1, 12'hB00, 8'hFF, 8'h00}, '{1'b1, 12'hB01, 8'hFF, 8'h00},
    '{1'b0, 12'hB02, 8'h00, 8'h00}, '{1'b0, 12'hB03, 8'h00, 8'h00},
    '{1'b1, 12'h100, 8'hAB, 8'h00}};
  ccs_host_model i_host (
    .sclk_out      (sclk),
    .reg_wr_out    (host_wr),
    .reg_addr_out  (host_addr),
    .reg_wdata_out (host_wdata),
    .reg_rdata_in  (rdata)
  );
  ccs_top i_dut (
    .ref_clk_in                (ref_clk_in),
    .rst_b_in                  (rst_b_in),
    .sclk_in                   (sclk),
    .mem_sel_in                (mem_sel_in),
    .reg_wr_in                 (host_wr),
    .reg_addr_in               (host_addr),
    .reg_wdata_in              (host_wdata),
    .reg_rdata_out             (rdata),
    .input_loop_power_down_out (pd_in),
    .synth_loop_power_down_out (pd_syn),
    .dist_power_down_out       (pd_dist),
    .status_pin_zero_out       (stat)
  );
  initial begin
    ref_clk_in = 1'b0;
    forever #20 ref_clk_in = ~ref_clk_in;
  end
  task automatic report_and_stop();
    if (failures == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input ccs_byte_t got, input ccs_byte_t exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Polls the pending flag until it drops, noting whether the status pin rose
  task automatic wait_done(output logic seen);
    ccs_byte_t v;
    seen = 1'b0;
    for (int n = 0; n < 400; n++) begin
      i_host.rd(12'hB00, v);
      if (stat === 1'b1) seen = 1'b1;
      if (v[0] === 1'b0) return;
    end
    failures++;
    report_and_stop();
  endtask
  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      report_and_stop();
    end
  end
  initial begin
    ccs_byte_t v;
    logic      seen;
    rst_b_in   = 1'b0;
    mem_sel_in = 1'b1;
    repeat (4) @(posedge ref_clk_in);
    #1;
    chk({5'h00, pd_in, pd_syn, pd_dist}, 8'h07);
    chk({7'h00, stat}, 8'h00);
    @(posedge ref_clk_in);
    rst_b_in <= 1'b1;
    repeat (6) @(posedge sclk);
    foreach (rows[i]) begin
      if (rows[i].wr) i_host.wr(rows[i].addr, rows[i].data);
      i_host.rd(rows[i].addr, v);
      chk(v, rows[i].exp);
    end
    chk({5'h00, pd_in, pd_syn, pd_dist}, 8'h07);
    i_host.wr(12'h233, 8'h05);
    i_host.wr(12'h234, 8'h01);
    i_host.rd(12'h234, v);
    i_host.rd(12'h234, v);
    chk(v, 8'h00);
    chk({5'h00, pd_in, pd_syn, pd_dist}, 8'h05);
    i_host.wr(12'hB03, 8'h01);
    i_host.rd(12'hB00, v);
    chk(v, 8'h00);
    i_host.rd(12'hB03, v);
    chk(v, 8'h00);
    i_host.wr(12'h232, 8'h10);
    i_host.wr(12'h234, 8'h01);
    i_host.wr(12'hB02, 8'h01);
    i_host.wr(12'hB03, 8'h01);
    i_host.rd(12'hB00, v);
    chk(v, 8'h01);
    wait_done(seen);
    chk({7'h00, seen}, 8'h01);
    i_host.rd(12'hB03, v);
    chk(v, 8'h00);
    i_host.rd(12'hB01, v);
    chk(v, 8'h00);
    repeat (4) @(posedge ref_clk_in);
    #1;
    chk({7'h00, stat}, 8'h00);
    i_host.wr(12'h233, 8'h02);
    i_host.rd(12'h233, v);
    chk({5'h00, pd_in, pd_syn, pd_dist}, 8'h05);
    i_host.wr(12'h234, 8'h01);
    i_host.wr(12'hB02, 8'h03);
    i_host.rd(12'hB00, v);
    chk(v, 8'h00);
    i_host.rd(12'hB02, v);
    chk(v, 8'h01);
    chk({5'h00, pd_in, pd_syn, pd_dist}, 8'h02);
    @(posedge ref_clk_in);
    mem_sel_in <= 1'b0;
    repeat (4) @(posedge ref_clk_in);
    i_host.wr(12'hB02, 8'h03);
    i_host.rd(12'hB00, v);
    chk(v, 8'h01);
    wait_done(seen);
    i_host.rd(12'hB02, v);
    chk(v, 8'h01);
    i_host.rd(12'h233, v);
    chk(v, 8'h05);
    chk({5'h00, pd_in, pd_syn, pd_dist}, 8'h05);
    i_host.rd(12'hB01, v);
    chk(v, 8'h00);
    // Refused save must leave the stored image intact
    i_host.wr(12'h233, 8'h03);
    i_host.wr(12'hB02, 8'h00);
    i_host.wr(12'hB03, 8'h01);
    i_host.wr(12'hB02, 8'h02);
    wait_done(seen);
    i_host.rd(12'h233, v);
    chk(v, 8'h05);
    // One-byte table takes a stored data byte as checksum
    i_host.wr(12'hA00, 8'h00);
    i_host.wr(12'hB02, 8'h02);
    wait_done(seen);
    i_host.rd(12'hB01, v);
    chk(v, 8'h01);
    // Reset after the failed reload restores defaults
    @(posedge ref_clk_in);
    rst_b_in <= 1'b0;
    repeat (4) @(posedge ref_clk_in);
    #1;
    chk({7'h00, stat}, 8'h00);
    @(posedge ref_clk_in);
    rst_b_in <= 1'b1;
    repeat (6) @(posedge sclk);
    i_host.rd(12'hA00, v);
    chk(v, 8'h01);
    i_host.rd(12'hB01, v);
    chk(v, 8'h00);
    chk({5'h00, pd_in, pd_syn, pd_dist}, 8'h07);
    report_and_stop();
  end
endmodule
